// *** rtl/sia_top.sv ***
// subtract, borrow, increment, decrement and clear datapath, ahb-lite slave
//
// Notes on behaviour
// - memory minus accumulator, written back to memory
// - accumulator minus memory minus carry into accumulator
// - memory minus accumulator minus carry into memory
// - accumulator minus carry into accumulator
// - memory minus carry into memory
// - increment memory byte in place
// - decrement memory byte in place
// - clear memory byte, accumulator untouched
`timescale 1ns/10ps
module sia_top
  import sia_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // ahb-lite slave
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  // memory write-back
  output logic                   mem_wr_out,
  output logic      [DATA_W-1:0] mem_wdata_out,
  // core state
  output logic      [DATA_W-1:0] acc_out,
  output logic      [3:0]        flags_out
);

  logic [DATA_W-1:0] accumulator_register;
  logic [DATA_W-1:0] mem_byte;
  sia_flags_t        flags;
  sia_op_t           last_op;
  logic              wr_pend;
  logic              rd_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic              addr_ok;
  logic              exec;
  sia_op_t           cmd_op;
  logic              carry_now;

  sia_alu_if alu ();

  // read mux, upper bits read as zero
  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] acc_v,
    input logic [DATA_W-1:0] mem_v,
    input sia_flags_t        flg_v,
    input sia_op_t           op_v
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      ADDR_ACC:  w[DATA_W-1:0] = acc_v;
      ADDR_MEM:  w[DATA_W-1:0] = mem_v;
      ADDR_FLAG: w[3:0] = flg_v;
      ADDR_CMD:  w[2:0] = op_v;
      default:   w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // address phase accepted: nonseq or seq, word sized
  assign addr_ok = hsel_in && htrans_in[1] && hready_in &&
                   (hsize_in == HSIZE_WORD);
  assign cmd_op = sia_op_t'(hwdata_in[2:0]);
  assign exec = wr_pend && (wr_addr == ADDR_CMD);
  assign carry_now = flags.carry_flag;

  // operands to the core
  assign alu.op = cmd_op;
  assign alu.acc = accumulator_register;
  assign alu.mem = mem_byte;
  assign alu.carry = carry_now;

  sia_alu_core sia_alu_core_i (
    .alu (alu)
  );

  // write data phase follows the accepted address phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend <= 1'h0;
      wr_addr <= ADDR_ACC;
    end else begin
      wr_pend <= addr_ok && hwrite_in;
      if (addr_ok && hwrite_in) begin
        wr_addr <= haddr_in[ADDR_W-1:0];
      end
    end
  end

  // reads take one wait state, data loaded from registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_pend <= 1'h0;
      rd_addr <= ADDR_ACC;
      hreadyout_out <= 1'h1;
      hrdata_out <= 32'h0000_0000;
    end else if (rd_pend) begin
      rd_pend <= 1'h0;
      hreadyout_out <= 1'h1;
      hrdata_out <= read_word(rd_addr, accumulator_register, mem_byte,
                              flags, last_op);
    end else if (addr_ok && !hwrite_in) begin
      rd_pend <= 1'h1;
      rd_addr <= haddr_in[ADDR_W-1:0];
      hreadyout_out <= 1'h0;
    end
  end

  // response is always okay
  always_ff @(posedge clk_in) begin
    hresp_out <= HRESP_OKAY;
  end

  // accumulator: software write or accumulator-destination result
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      accumulator_register <= ACC_RST;
    end else if (exec && alu.to_acc) begin
      accumulator_register <= alu.res.val;
    end else if (wr_pend && wr_addr == ADDR_ACC) begin
      accumulator_register <= hwdata_in[DATA_W-1:0];
    end
  end

  // addressed memory byte: software load or memory-destination result
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_byte <= MEM_RST;
    end else if (exec && !alu.to_acc) begin
      mem_byte <= alu.res.val;
    end else if (wr_pend && wr_addr == ADDR_MEM) begin
      mem_byte <= hwdata_in[DATA_W-1:0];
    end
  end

  // flags from every operation, or a software write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags <= FLAG_RST;
    end else if (exec) begin
      flags <= alu.res.flg;
    end else if (wr_pend && wr_addr == ADDR_FLAG) begin
      flags <= sia_flags_t'(hwdata_in[3:0]);
    end
  end

  // last operation and write-back strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_op <= OP_SUB_MA;
      mem_wr_out <= 1'h0;
      mem_wdata_out <= MEM_RST;
    end else begin
      mem_wr_out <= exec && !alu.to_acc;
      if (exec) begin
        last_op <= cmd_op;
        mem_wdata_out <= alu.res.val;
      end
    end
  end

  assign acc_out = accumulator_register;
  assign flags_out = flags;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_sub_mem_diff: assert property (
    exec && cmd_op == OP_SUB_MA |=>
      mem_byte == 8'($past(mem_byte) - $past(accumulator_register)))
    else $error("memory subtract result wrong");

  a_subc_acc_res: assert property (
    exec && cmd_op == OP_SUBC_AM |=>
      accumulator_register == 8'($past(accumulator_register) -
        $past(mem_byte) - {7'h00, $past(carry_now)}) && $stable(mem_byte))
    else $error("accumulator borrow subtract wrong");

  a_subc_mem_res: assert property (
    exec && cmd_op == OP_SUBC_MA |=>
      mem_byte == 8'($past(mem_byte) - $past(accumulator_register) -
        {7'h00, $past(carry_now)}) && $stable(accumulator_register))
    else $error("memory borrow subtract wrong");

  a_subc_acc_only: assert property (
    exec && cmd_op == OP_SUBC_A |=>
      accumulator_register == 8'($past(accumulator_register) -
        {7'h00, $past(carry_now)}))
    else $error("accumulator carry subtract wrong");

  a_subc_mem_only: assert property (
    exec && cmd_op == OP_SUBC_M |=>
      mem_byte == 8'($past(mem_byte) - {7'h00, $past(carry_now)}))
    else $error("memory carry subtract wrong");

  a_inc_mem_wb: assert property (
    exec && cmd_op == OP_INC_M |=>
      mem_wr_out && mem_wdata_out == 8'($past(mem_byte) + ONE_VAL) &&
      mem_byte == mem_wdata_out)
    else $error("increment write-back wrong");

  a_dec_mem_wb: assert property (
    exec && cmd_op == OP_DEC_M |=>
      mem_wr_out && mem_byte == 8'($past(mem_byte) - ONE_VAL))
    else $error("decrement write-back wrong");

  a_clear_keeps_acc: assert property (
    exec && cmd_op == OP_CLR_M |=>
      mem_byte == ZERO_VAL && $stable(accumulator_register) &&
      flags == 4'h1)
    else $error("clear result or flags wrong");

  a_borrow_carry: assert property (
    exec && cmd_op == OP_SUBC_AM |=>
      carry_now == ({1'h0, $past(accumulator_register)} <
        ({1'h0, $past(mem_byte)} + {8'h00, $past(carry_now)})))
    else $error("borrow flag wrong");

  a_zero_overflow: assert property (
    exec && cmd_op == OP_SUB_MA |=>
      flags.zero_flag == (mem_byte == ZERO_VAL) &&
      flags.overflow_flag == (($past(mem_byte[7]) !=
        $past(accumulator_register[7])) &&
        (mem_byte[7] != $past(mem_byte[7]))))
    else $error("zero or overflow flag wrong");

  a_read_wait: assert property (
    addr_ok && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");

  a_write_no_wait: assert property (
    addr_ok && hwrite_in |=> hreadyout_out)
    else $error("write wait state inserted");

  a_acc_write_lands: assert property (
    wr_pend && wr_addr == ADDR_ACC |=>
      accumulator_register == $past(hwdata_in[DATA_W-1:0]))
    else $error("accumulator write lost");

  a_mem_dest_pulse: assert property (
    exec && !alu.to_acc |=>
      mem_wr_out && mem_wdata_out == mem_byte &&
      $stable(accumulator_register))
    else $error("memory write-back strobe wrong");

  a_wr_only_exec: assert property (
    !exec |=> !mem_wr_out)
    else $error("stray memory write strobe");

  a_acc_dest_hold: assert property (
    exec && alu.to_acc |=> !mem_wr_out && $stable(mem_byte))
    else $error("accumulator operation touched memory");

  a_inc_carry_out: assert property (
    exec && cmd_op == OP_INC_M |=>
      flags.carry_flag == (&$past(mem_byte)))
    else $error("increment carry wrong");

  a_inc_aux_carry: assert property (
    exec && cmd_op == OP_INC_M |=>
      flags.aux_carry_flag == (&$past(mem_byte[3:0])))
    else $error("increment aux carry wrong");

  a_dec_borrow: assert property (
    exec && cmd_op == OP_DEC_M |=>
      flags.carry_flag == ($past(mem_byte) == ZERO_VAL))
    else $error("decrement borrow wrong");

  a_dec_aux_borrow: assert property (
    exec && cmd_op == OP_DEC_M |=>
      flags.aux_carry_flag == (~|$past(mem_byte[3:0])))
    else $error("decrement aux borrow wrong");

  a_subc_aux_borrow: assert property (
    exec && cmd_op == OP_SUBC_MA |=>
      flags.aux_carry_flag == ({1'h0, $past(mem_byte[3:0])} <
        {1'h0, $past(accumulator_register[3:0])} +
        {4'h0, $past(carry_now)}))
    else $error("borrow aux flag wrong");

  a_inc_overflow: assert property (
    exec && cmd_op == OP_INC_M |=>
      flags.zero_flag == (mem_byte == ZERO_VAL) &&
      flags.overflow_flag == (!$past(mem_byte[DATA_W-1]) &&
        mem_byte[DATA_W-1]))
    else $error("increment zero or overflow wrong");

  a_dec_overflow: assert property (
    exec && cmd_op == OP_DEC_M |=>
      flags.overflow_flag == ($past(mem_byte[DATA_W-1]) &&
        !mem_byte[DATA_W-1]))
    else $error("decrement overflow wrong");

endmodule : sia_top

// *** rtl/sia_pkg.sv ***
// shared constants, types and arithmetic for the subtract/inc/dec datapath
package sia_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_ACC  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MEM  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CMD  = 8'h0C;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  // reset values and constant operands
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] MEM_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;
  localparam logic [DATA_W-1:0] ONE_VAL  = 8'h01;

  // operation codes, written to the command register
  typedef enum logic [2:0] {
    OP_SUB_MA  = 3'h0,
    OP_SUBC_AM = 3'h1,
    OP_SUBC_MA = 3'h2,
    OP_SUBC_A  = 3'h3,
    OP_SUBC_M  = 3'h4,
    OP_INC_M   = 3'h5,
    OP_DEC_M   = 3'h6,
    OP_CLR_M   = 3'h7
  } sia_op_t;

  // flag layout: bit3 overflow, bit2 aux carry, bit1 carry, bit0 zero
  typedef struct packed {
    logic overflow_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic zero_flag;
  } sia_flags_t;

  localparam sia_flags_t FLAG_RST = 4'h0;

  typedef struct packed {
    logic [DATA_W-1:0] val;
    sia_flags_t        flg;
  } sia_res_t;

  // x + y + cin, or x - y - cin when sub is set; carry means borrow
  function automatic sia_res_t sia_arith(
    input logic [DATA_W-1:0] x,
    input logic [DATA_W-1:0] y,
    input logic              cin,
    input logic              sub
  );
    logic [DATA_W-1:0] yy;
    logic [DATA_W:0]   s;
    logic [4:0]        n;
    sia_res_t          r;
    yy = sub ? ~y : y;
    s = {1'h0, x} + {1'h0, yy} + {8'h00, cin ^ sub};
    n = {1'h0, x[3:0]} + {1'h0, yy[3:0]} + {4'h0, cin ^ sub};
    r.val = s[DATA_W-1:0];
    r.flg.zero_flag = (s[DATA_W-1:0] == ZERO_VAL);
    r.flg.carry_flag = s[DATA_W] ^ sub;
    r.flg.aux_carry_flag = n[4] ^ sub;
    r.flg.overflow_flag = (x[DATA_W-1] == yy[DATA_W-1]) &&
                          (s[DATA_W-1] != x[DATA_W-1]);
    return r;
  endfunction : sia_arith

endpackage : sia_pkg

// *** rtl/sia_alu_if.sv ***
// operand and result carrier between the top and the arithmetic core
`timescale 1ns/10ps
interface sia_alu_if;
  import sia_pkg::*;

  sia_op_t           op;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] mem;
  logic              carry;
  sia_res_t          res;
  logic              to_acc;

  modport core (
    input  op,
    input  acc,
    input  mem,
    input  carry,
    output res,
    output to_acc
  );

  modport user (
    output op,
    output acc,
    output mem,
    output carry,
    input  res,
    input  to_acc
  );
endinterface : sia_alu_if

// *** rtl/sia_alu_core.sv ***
// combinational result and flag generation for each operation
`timescale 1ns/10ps
module sia_alu_core
  import sia_pkg::*;
(
  // operands in, result out
  sia_alu_if.core alu
);

  always_comb begin
    alu.to_acc = 1'h0;
    case (alu.op)
      OP_SUB_MA: begin
        alu.res = sia_arith(alu.mem, alu.acc, 1'h0, 1'h1);
      end
      OP_SUBC_AM: begin
        alu.res = sia_arith(alu.acc, alu.mem, alu.carry, 1'h1);
        alu.to_acc = 1'h1;
      end
      OP_SUBC_MA: begin
        alu.res = sia_arith(alu.mem, alu.acc, alu.carry, 1'h1);
      end
      OP_SUBC_A: begin
        alu.res = sia_arith(alu.acc, ZERO_VAL, alu.carry, 1'h1);
        alu.to_acc = 1'h1;
      end
      OP_SUBC_M: begin
        alu.res = sia_arith(alu.mem, ZERO_VAL, alu.carry, 1'h1);
      end
      OP_INC_M: begin
        alu.res = sia_arith(alu.mem, ONE_VAL, 1'h0, 1'h0);
      end
      OP_DEC_M: begin
        alu.res = sia_arith(alu.mem, ONE_VAL, 1'h0, 1'h1);
      end
      OP_CLR_M: begin
        // zero minus zero gives zero with z set, others clear
        alu.res = sia_arith(ZERO_VAL, ZERO_VAL, 1'h0, 1'h1);
      end
      default: begin
        alu.res = sia_arith(alu.mem, ZERO_VAL, 1'h0, 1'h0);
      end
    endcase
  end

endmodule : sia_alu_core

// *** tb/subtract_inc_dec_alu_ops_test.sv ***
// self-checking bench for the subtract/inc/dec datapath over ahb-lite
`timescale 1ns/10ps
module subtract_inc_dec_alu_ops_test;
  import sia_pkg::*;

  logic        clk_in    = 1'b0;
  logic        rst_in    = 1'b1;
  logic        hsel_in   = 1'b0;
  logic [31:0] haddr_in  = 32'h0;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'b0;
  logic [2:0]  hsize_in  = HSIZE_WORD;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        mem_wr_out;
  logic [7:0]  mem_wdata_out;
  logic [7:0]  acc_out;
  logic [3:0]  flags_out;
  logic [31:0] rd;
  int          failures   = 0;
  int          n_compared = 0;

  always #12.5 clk_in = ~clk_in;

  sia_top sia_top_i (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hreadyout_out),
    .hrdata_out    (hrdata_out),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .mem_wr_out    (mem_wr_out),
    .mem_wdata_out (mem_wdata_out),
    .acc_out       (acc_out),
    .flags_out     (flags_out)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // one transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h000000, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    hsize_in  <= sz;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, HSIZE_WORD);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, HSIZE_WORD);
    check(rd, exp);
  endtask : rd_chk

  task automatic do_reset(input int n);
    rst_in <= 1'b1;
    repeat (n) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
  endtask : do_reset

  // reference: {acc, mem, flags, memory destination}
  function automatic logic [20:0] ref_op(input logic [2:0] op,
      input logic [7:0] a, input logic [7:0] m, input logic c);
    logic [7:0] x, y, r;
    logic [8:0] w;
    logic [4:0] n;
    logic [3:0] f;
    logic       b, s, dst, ov;
    x = m; y = a; b = 1'b0; s = 1'b1; dst = 1'b1;
    case (op)
      3'h1: begin x = a; y = m; b = c; dst = 1'b0; end
      3'h2: b = c;
      3'h3: begin x = a; y = 8'h00; b = c; dst = 1'b0; end
      3'h4: begin y = 8'h00; b = c; end
      3'h5: begin y = 8'h01; s = 1'b0; end
      3'h6: y = 8'h01;
      default: ;
    endcase
    w = s ? {1'b0, x} - {1'b0, y} - {8'h00, b} : {1'b0, x} + {1'b0, y};
    n = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, b}
          : {1'b0, x[3:0]} + {1'b0, y[3:0]};
    r = w[7:0];
    ov = (s ? (x[7] != y[7]) : (x[7] == y[7])) && (r[7] != x[7]);
    f = {ov, n[4], w[8], r == 8'h00};
    if (op == 3'h7) begin
      r = 8'h00;
      f = 4'h1;
    end
    return {dst ? a : r, dst ? r : m, f, dst};
  endfunction : ref_op

  task automatic t_reset_values;
    check({24'h0, acc_out}, 32'h0);
    check({28'h0, flags_out}, 32'h0);
    check({31'h0, hresp_out}, {31'h0, HRESP_OKAY});
    rd_chk(ADDR_ACC, 32'h0);
    rd_chk(ADDR_MEM, 32'h0);
    rd_chk(ADDR_FLAG, 32'h0);
    $display("reset values done");
  endtask : t_reset_values

  // every op code against four operand sets with boundary values
  task automatic t_all_ops;
    logic [7:0] va [4] = '{8'h01, 8'h10, 8'h00, 8'h7F};
    logic [7:0] vm [4] = '{8'h80, 8'h10, 8'hFF, 8'h00};
    logic       vc [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [20:0] e;
    for (int v = 0; v < 4; v++) begin
      for (int i = 0; i < 8; i++) begin
        e = ref_op(i[2:0], va[v], vm[v], vc[v]);
        wr(ADDR_ACC, {24'h0, va[v]});
        wr(ADDR_MEM, {24'h0, vm[v]});
        wr(ADDR_FLAG, {30'h0, vc[v], 1'b0});
        wr(ADDR_CMD, {29'h0, i[2:0]});
        #1;
        check({24'h0, acc_out}, {24'h0, e[20:13]});
        check({28'h0, flags_out}, {28'h0, e[4:1]});
        check({31'h0, mem_wr_out}, {31'h0, e[0]});
        if (e[0]) begin
          check({24'h0, mem_wdata_out}, {24'h0, e[12:5]});
        end
        rd_chk(ADDR_MEM, {24'h0, e[12:5]});
        rd_chk(ADDR_ACC, {24'h0, e[20:13]});
        rd_chk(ADDR_FLAG, {28'h0, e[4:1]});
        rd_chk(ADDR_CMD, {29'h0, i[2:0]});
        check({31'h0, mem_wr_out}, 32'h0);
      end
    end
    $display("all operations done");
  endtask : t_all_ops

  // unmapped offsets and a reset in mid-run
  task automatic t_refused;
    wr(ADDR_ACC, 32'h0000_005A);
    wr(8'h10, 32'h0000_00A5);
    rd_chk(8'h10, 32'h0);
    wr(8'h14, 32'h0000_0033);
    rd_chk(ADDR_ACC, 32'h0000_005A);
    check({31'h0, hresp_out}, {31'h0, HRESP_OKAY});
    do_reset(2);
    #1;
    check({24'h0, acc_out}, 32'h0);
    rd_chk(ADDR_ACC, 32'h0);
    $display("refused accesses done");
  endtask : t_refused

  initial begin
    #(25 * 20000);
    failures++;
    conclude();
  end

  initial begin
    do_reset(8);
    t_reset_values();
    t_all_ops();
    t_refused();
    conclude();
  end
endmodule : subtract_inc_dec_alu_ops_test
